/* File: ext_edge_irq_pkg.sv */
// ext_edge_irq_pkg: register map, field layout and reset values of the
// external edge interrupt control block.
// assumes a 32-bit classic wishbone bus with one register per aligned word.

`default_nettype none

package ext_edge_irq_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] TIMER_EXT_REQ_IDX    = 8'h88;
  localparam logic [7:0] SERIAL_ENABLE_IDX    = 8'haa;
  localparam logic [7:0] G0_FALL_IDX          = 8'hb4;
  localparam logic [7:0] SERIAL_PRIO_IDX      = 8'hba;
  localparam logic [7:0] G0_RISE_IDX          = 8'hbb;
  localparam logic [7:0] G1_FALL_IDX          = 8'hbc;
  localparam logic [7:0] G1_RISE_IDX          = 8'hbd;
  localparam logic [7:0] G2_FALL_IDX          = 8'hbe;
  localparam logic [7:0] G2_RISE_IDX          = 8'hbf;
  localparam logic [7:0] IRQ_STATUS_IDX       = 8'hc0;
  localparam logic [7:0] IRQ_MASK_IDX         = 8'hc1;

  // ==========================================================================
  // field positions and writable bits
  localparam int         GROUP1_FLAG_BIT      = 3;
  localparam int         GROUP0_FLAG_BIT      = 1;
  localparam logic [7:0] SERIAL_ENABLE_BITS   = 8'h07;
  localparam logic [7:0] SERIAL_PRIO_BITS     = 8'h1f;
  localparam logic [7:0] G0_EDGE_BITS         = 8'hf0;
  localparam logic [7:0] G1_EDGE_BITS         = 8'hff;
  localparam logic [7:0] G2_EDGE_BITS         = 8'h0f;
  localparam int         STATUS_G0_BIT        = 0;
  localparam int         STATUS_G1_BIT        = 1;
  localparam int         STATUS_G2_BIT        = 2;
  localparam logic [2:0] STATUS_BITS          = 3'h7;

  // ==========================================================================
  // reset values
  localparam logic [7:0] CFG_RESET            = 8'h00;
  localparam logic [2:0] STATUS_RESET         = 3'h0;
  localparam logic       FLAG_RESET           = 1'b0;

  // external pins of the three groups, group 0 holds lines 7..4
  typedef struct packed {
    logic [3:0] group2;
    logic [7:0] group1;
    logic [3:0] group0;
  } ext_lines_s;

  // serial unit settings as seen by the core's arbiter
  typedef struct packed {
    logic [4:0] irqPriority;
    logic [2:0] irqEnable;
  } serial_cfg_s;

endpackage : ext_edge_irq_pkg

`default_nettype wire

/* File: ext_edge_interrupt_control.sv */
// ext_edge_interrupt_control: serial interrupt enables and priorities,
// per-line edge enables and group request flags for external interrupts.
// assumes pins are asynchronous, serial sources and cpu acks share clock.
//
// Register access over Wishbone was chosen for this implementation.

`timescale 1ns/100ps
`default_nettype none

module ext_edge_interrupt_control
  import ext_edge_irq_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output var  logic [31:0] dat_o,
  output var  logic        ack_o,
  // external interrupt pins
  input  wire ext_lines_s  extLines,
  // serial unit sources and their gated requests
  input  wire logic [2:0]  serialIrqSource,
  output var  logic [2:0]  serialIrqRequest,
  output var  serial_cfg_s serialCfg,
  // cpu acknowledge and group requests
  input  wire logic        cpuAckGroup0,
  input  wire logic        cpuAckGroup1,
  input  wire logic        cpuAckGroup2,
  output var  logic        group0Request,
  output var  logic        group1Request,
  output var  logic        group2Request,
  // summary interrupt
  output var  logic        irq
);

  localparam int NLINES = 16;

  // ==========================================================================
  // elaboration checks
  if (SYNC_STAGES != 2) begin : g_badSync
    $error("only two synchroniser stages are supported");
  end

  // ==========================================================================
  // bus decode
  logic       wbTake;
  logic       wbWrite;
  logic [7:0] regIdx;
  logic [7:0] wrByte;

  // one request is taken per ack; ack drops the cycle after
  // a write lands only on the edge where the master sees ack, never earlier
  assign wbTake  = cyc_i && stb_i && !ack_o;
  assign wbWrite = cyc_i && stb_i && ack_o && we_i && sel_i[0];
  assign regIdx  = adr_i[9:2];
  assign wrByte  = dat_i[7:0];

  // ==========================================================================
  // configuration registers
  logic [7:0] serEn_q;
  logic [7:0] g0Fall_q;
  logic [7:0] g0Rise_q;
  logic [7:0] g1Fall_q;
  logic [7:0] g1Rise_q;
  logic [7:0] g2Fall_q;
  logic [7:0] g2Rise_q;
  logic [2:0] mask_q;

  // reserved bits never store, so they read back zero
  always_ff @(posedge clock) begin
    if (!resetn) begin
      serEn_q  <= CFG_RESET;
      g0Fall_q <= CFG_RESET;
      g0Rise_q <= CFG_RESET;
      g1Fall_q <= CFG_RESET;
      g1Rise_q <= CFG_RESET;
      g2Fall_q <= CFG_RESET;
      g2Rise_q <= CFG_RESET;
      mask_q   <= STATUS_RESET;
    end else if (wbWrite) begin
      case (regIdx)
        SERIAL_ENABLE_IDX: serEn_q  <= wrByte & SERIAL_ENABLE_BITS;
        G0_FALL_IDX:       g0Fall_q <= wrByte & G0_EDGE_BITS;
        G0_RISE_IDX:       g0Rise_q <= wrByte & G0_EDGE_BITS;
        G1_FALL_IDX:       g1Fall_q <= wrByte & G1_EDGE_BITS;
        G1_RISE_IDX:       g1Rise_q <= wrByte & G1_EDGE_BITS;
        G2_FALL_IDX:       g2Fall_q <= wrByte & G2_EDGE_BITS;
        G2_RISE_IDX:       g2Rise_q <= wrByte & G2_EDGE_BITS;
        IRQ_MASK_IDX:      mask_q   <= wrByte[2:0];
        default: begin
        end
      endcase
    end
  end

  // priority bits go straight out as the register itself
  always_ff @(posedge clock) begin
    if (!resetn) begin
      serialCfg.irqPriority <= CFG_RESET[4:0];
    end else if (wbWrite && regIdx == SERIAL_PRIO_IDX) begin
      serialCfg.irqPriority <= wrByte[4:0] & SERIAL_PRIO_BITS[4:0];
    end
  end

  // enable copy for the arbiter, one cycle behind the register
  always_ff @(posedge clock) begin
    if (!resetn) begin
      serialCfg.irqEnable <= CFG_RESET[2:0];
      serialIrqRequest    <= 3'h0;
    end else begin
      serialCfg.irqEnable <= serEn_q[2:0];
      serialIrqRequest    <= serialIrqSource & serEn_q[2:0];
    end
  end

  // ==========================================================================
  // pin synchronisers and edge detection
  logic [NLINES-1:0] meta_q;
  logic [NLINES-1:0] sync_q;
  logic [NLINES-1:0] prev_q;
  logic [NLINES-1:0] riseEn;
  logic [NLINES-1:0] fallEn;
  logic [NLINES-1:0] riseVec;
  logic [NLINES-1:0] fallVec;
  logic [NLINES-1:0] lineHit;

  // meta_q feeds sync_q only; prev_q holds the last settled level
  always_ff @(posedge clock) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= extLines;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // enables lined up with the pin struct: group2, group1, group0 lines 7..4
  assign riseEn  = {g2Rise_q[3:0], g1Rise_q, g0Rise_q[7:4]};
  assign fallEn  = {g2Fall_q[3:0], g1Fall_q, g0Fall_q[7:4]};
  assign riseVec = sync_q & ~prev_q;
  assign fallVec = ~sync_q & prev_q;

  // per line: both enables set means either edge requests
  for (genvar i = 0; i < NLINES; i++) begin : g_line
    assign lineHit[i] = (riseVec[i] & riseEn[i]) | (fallVec[i] & fallEn[i]);
  end

  logic groupEvent0;
  logic groupEvent1;
  logic groupEvent2;

  // any enabled edge of a group raises its single event
  assign groupEvent0 = |lineHit[3:0];
  assign groupEvent1 = |lineHit[11:4];
  assign groupEvent2 = |lineHit[15:12];

  // ==========================================================================
  // group request flags
  logic tconWrite;

  assign tconWrite = wbWrite && regIdx == TIMER_EXT_REQ_IDX;

  // set wins over both the acknowledge and a software write of zero
  always_ff @(posedge clock) begin
    if (!resetn) begin
      group1Request <= FLAG_RESET;
    end else if (groupEvent1) begin
      group1Request <= 1'b1;
    end else if (cpuAckGroup1) begin
      group1Request <= 1'b0;
    end else if (tconWrite) begin
      group1Request <= wrByte[GROUP1_FLAG_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      group0Request <= FLAG_RESET;
    end else if (groupEvent0) begin
      group0Request <= 1'b1;
    end else if (cpuAckGroup0) begin
      group0Request <= 1'b0;
    end else if (tconWrite) begin
      group0Request <= wrByte[GROUP0_FLAG_BIT];
    end
  end

  // group two has no timer-register flag; this one shows only at group2Request, and status keeps its own sticky bit
  always_ff @(posedge clock) begin
    if (!resetn) begin
      group2Request <= FLAG_RESET;
    end else if (groupEvent2) begin
      group2Request <= 1'b1;
    end else if (cpuAckGroup2) begin
      group2Request <= 1'b0;
    end
  end

  // ==========================================================================
  // sticky status, write one to clear, set wins
  logic [2:0] status_q;
  logic [2:0] statusSet;
  logic [2:0] statusClr;

  assign statusSet = {groupEvent2, groupEvent1, groupEvent0};
  assign statusClr = (wbWrite && regIdx == IRQ_STATUS_IDX) ? wrByte[2:0] : 3'h0;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= ((status_q & ~statusClr) | statusSet) & STATUS_BITS;
    end
  end

  // level output, registered so it trails the status by one cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  // ==========================================================================
  // read mux and ack
  logic [7:0] readByte;

  always_comb begin
    readByte = 8'h00;
    case (regIdx)
      TIMER_EXT_REQ_IDX: begin
        readByte[GROUP1_FLAG_BIT] = group1Request;
        readByte[GROUP0_FLAG_BIT] = group0Request;
      end
      SERIAL_ENABLE_IDX: readByte = serEn_q;
      SERIAL_PRIO_IDX:   readByte = {3'h0, serialCfg.irqPriority};
      G0_FALL_IDX:       readByte = g0Fall_q;
      G0_RISE_IDX:       readByte = g0Rise_q;
      G1_FALL_IDX:       readByte = g1Fall_q;
      G1_RISE_IDX:       readByte = g1Rise_q;
      G2_FALL_IDX:       readByte = g2Fall_q;
      G2_RISE_IDX:       readByte = g2Rise_q;
      IRQ_STATUS_IDX:    readByte = {5'h00, status_q};
      IRQ_MASK_IDX:      readByte = {5'h00, mask_q};
      default:           readByte = 8'h00; // unmapped reads zero, still acked
    endcase
  end

  // one wait state: ack and data follow the edge that takes the request
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= wbTake;
      if (wbTake && !we_i) begin
        dat_o <= {24'h00_0000, readByte};
      end
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  sequence prioWrite;
    wbWrite && regIdx == SERIAL_PRIO_IDX;
  endsequence
  sequence g0FallRead;
    wbTake && !we_i && regIdx == G0_FALL_IDX;
  endsequence
  chk_serial_gate: assert property (
    ##1 serialIrqRequest == ($past(serialIrqSource) & $past(serEn_q[2:0])))
    else $error("serial request not gated by its enable");
  chk_prio_store: assert property (
    prioWrite |=> serialCfg.irqPriority == $past(dat_i[4:0]))
    else $error("priority register did not take the written value");
  chk_flag1_set: assert property (
    groupEvent1 |=> group1Request [*1] ##0 status_q[STATUS_G1_BIT])
    else $error("group one event did not set its flag");
  chk_flag1_clear: assert property (
    group1Request && cpuAckGroup1 && !groupEvent1 |=> !group1Request)
    else $error("group one flag not cleared by acknowledge");
  chk_flag0_cycle: assert property (
    groupEvent0 |=> group0Request ##0 status_q[STATUS_G0_BIT])
    else $error("group zero event did not set flag and status");
  chk_flag0_clear: assert property (
    group0Request && cpuAckGroup0 && !groupEvent0 |=> !group0Request)
    else $error("group zero flag not cleared by acknowledge");
  chk_g0_fall: assert property (
    |(fallVec[3:0] & g0Fall_q[7:4]) |=> group0Request)
    else $error("group zero falling edge missed");
  chk_g0_rise: assert property (
    |(riseVec[3:0] & g0Rise_q[7:4]) |=> group0Request)
    else $error("group zero rising edge missed");
  chk_g1_edges: assert property (
    |((fallVec[11:4] & g1Fall_q) | (riseVec[11:4] & g1Rise_q)) |=> group1Request)
    else $error("group one edge missed");
  chk_g2_edges: assert property (
    |((fallVec[15:12] & g2Fall_q[3:0]) | (riseVec[15:12] & g2Rise_q[3:0]))
      |=> group2Request ##0 status_q[STATUS_G2_BIT])
    else $error("group two edge missed");
  chk_no_spurious: assert property (
    !group0Request && !groupEvent0 && !tconWrite |=> !group0Request)
    else $error("group zero flag set without an enabled edge");
  chk_reserved_zero: assert property (
    g0FallRead |=> dat_o[3:0] == 4'h0 && ack_o)
    else $error("reserved bits of group zero falling enable not zero");

endmodule : ext_edge_interrupt_control

`default_nettype wire

/* File: ext_side_model.sv */
// ext_side_model: the far side of the edge interrupt block, the board pins
// and the cpu core that services group requests.
// assumes the bench commands pin levels and which groups the cpu serves.
`timescale 1ns/100ps
`default_nettype none
module ext_side_model
  import ext_edge_irq_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // bench commands
  input  wire logic [15:0] pinDrive,
  input  wire logic [2:0] service,
  // device side
  input  wire logic [2:0] requests,
  output var  ext_lines_s extLines,
  output var  logic [2:0] cpuAck
);
  // =========================================================================
  // pins move just after an edge, like any board source
  always_ff @(posedge clock) extLines <= pinDrive;
  // one ack pulse per served request; a slow cpu is the bench delaying service
  always_ff @(posedge clock) begin
    if (!resetn) cpuAck <= 3'h0;
    else cpuAck <= service & requests & ~cpuAck;
  end
endmodule : ext_side_model
`default_nettype wire

/* File: ext_edge_interrupt_control_bench.sv */
// ext_edge_interrupt_control_bench: self-checking bench of the edge
// interrupt control block, registers driven over classic wishbone.
// assumes the package constants and one 50 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module ext_edge_interrupt_control_bench
  import ext_edge_irq_pkg::*;
;
  localparam logic [7:0] IDX [11] = '{TIMER_EXT_REQ_IDX, SERIAL_ENABLE_IDX, SERIAL_PRIO_IDX,
    G0_FALL_IDX, G0_RISE_IDX, G1_FALL_IDX, G1_RISE_IDX, G2_FALL_IDX, G2_RISE_IDX,
    IRQ_MASK_IDX, 8'h10};
  localparam logic [7:0] MSK [11] = '{8'h0a, SERIAL_ENABLE_BITS, SERIAL_PRIO_BITS,
    G0_EDGE_BITS, G0_EDGE_BITS, G1_EDGE_BITS, G1_EDGE_BITS, G2_EDGE_BITS, G2_EDGE_BITS,
    {5'h0, STATUS_BITS}, 8'h00};
  localparam logic [7:0] RISE [3] = '{G0_RISE_IDX, G1_RISE_IDX, G2_RISE_IDX};
  localparam logic [7:0] FALL [3] = '{G0_FALL_IDX, G1_FALL_IDX, G2_FALL_IDX};
  logic        clock, resetn, cyc, stb, we, ack, irq, g0, g1, g2;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datW, datR, d;
  logic [15:0] pinDrive;
  logic [2:0]  service, cpuAck, src, serReq, req;
  logic [7:0]  v, w;
  ext_lines_s  extLines;
  serial_cfg_s cfg;
  int          n_fail, n_compared, g, k, m, r;
  assign req = {g2, g1, g0};

  // =========================================================================
  ext_edge_interrupt_control ext_edge_interrupt_control_i (.clock(clock), .resetn(resetn),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW),
    .dat_o(datR), .ack_o(ack), .extLines(extLines), .serialIrqSource(src),
    .serialIrqRequest(serReq), .serialCfg(cfg), .cpuAckGroup0(cpuAck[0]),
    .cpuAckGroup1(cpuAck[1]), .cpuAckGroup2(cpuAck[2]), .group0Request(g0),
    .group1Request(g1), .group2Request(g2), .irq(irq));
  ext_side_model ext_side_model_i (.clock(clock), .resetn(resetn), .pinDrive(pinDrive),
    .service(service), .requests(req), .extLines(extLines), .cpuAck(cpuAck));

  // =========================================================================
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // a hang counts as a failure and ends the run at once
  task automatic timeout();
    n_fail++;
    $display("mismatch t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
    results();
  endtask : timeout
  // classic cycle: held until ack is sampled, then released for a cycle
  task automatic wb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                    input logic [3:0] s, output logic [31:0] rdat);
    int i;
    cyc <= 1'b1; stb <= 1'b1; we <= wr; adr <= {idx, 2'b00}; datW <= {24'h0, wd}; sel <= s;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (ack === 1'b1) break;
    end
    if (i == 20) timeout();
    rdat = datR;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clock);
  endtask : wb
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] x;
    wb(1'b1, idx, wd, 4'h1, x);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] x;
    wb(1'b0, idx, 8'h00, 4'h1, x);
    check(x, {24'h0, exp});
  endtask : rd
  task automatic waitReq(input int grp, input logic val);
    int i;
    for (i = 0; i < 12 && req[grp] !== val; i++) @(posedge clock);
    if (i == 12) timeout();
  endtask : waitReq
  // an enabled edge raises only its group flag; the cpu ack clears it
  task automatic edgeCheck(input int grp, input logic hit);
    if (!hit) begin
      repeat (8) @(posedge clock);
      check(req, 32'h0);
      return;
    end
    waitReq(grp, 1'b1);
    check(req, 32'h1 << grp);
    if (grp < 2) rd(TIMER_EXT_REQ_IDX, 8'h01 << (grp ? GROUP1_FLAG_BIT : GROUP0_FLAG_BIT));
    service <= 3'(1 << grp);
    waitReq(grp, 1'b0);
    service <= 3'h0;
    check(req, 32'h0);
  endtask : edgeCheck
  function automatic logic [7:0] lineBit(input int n);
    return 8'h01 << (n < 4 ? n + 4 : (n < 12 ? n - 4 : n - 12));
  endfunction : lineBit

  // =========================================================================
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // main sequence
  initial begin
    resetn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = '0; datW = '0;
    pinDrive = '0; service = '0; src = '0; n_fail = 0; n_compared = 0;
    v = 8'($urandom(38));
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (IDX[i]) rd(IDX[i], 8'h00);
    rd(IRQ_STATUS_IDX, 8'h00);
    for (r = 0; r < 4; r++) foreach (IDX[i]) begin
      v = (r == 0) ? 8'hff : 8'($urandom);
      wr(IDX[i], v);
      rd(IDX[i], v & MSK[i]);
    end
    // a write without its byte lane is dropped
    wr(G1_RISE_IDX, 8'h5a);
    wb(1'b1, G1_RISE_IDX, 8'ha5, 4'he, d);
    rd(G1_RISE_IDX, 8'h5a);
    for (r = 0; r < 8; r++) begin
      v = (r == 0) ? 8'hff : 8'($urandom);
      w = 8'($urandom);
      wr(SERIAL_ENABLE_IDX, v);
      wr(SERIAL_PRIO_IDX, w);
      src <= 3'($urandom);
      repeat (3) @(posedge clock);
      check(serReq, src & v[2:0]);
      check(cfg, {w[4:0], v[2:0]});
    end
    wr(TIMER_EXT_REQ_IDX, 8'h00);
    wr(IRQ_MASK_IDX, 8'h00);
    wr(IRQ_STATUS_IDX, 8'h07);
    // every line, rising only, falling only, then both edges
    for (k = 0; k < 16; k++) for (m = 1; m < 4; m++) begin
      g = k < 4 ? 0 : (k < 12 ? 1 : 2);
      wr(RISE[g], m[0] ? lineBit(k) : 8'h00);
      wr(FALL[g], m[1] ? lineBit(k) : 8'h00);
      pinDrive[k] <= 1'b1;
      edgeCheck(g, m[0]);
      pinDrive[k] <= 1'b0;
      edgeCheck(g, m[1]);
    end
    // summary interrupt follows status under the mask
    rd(IRQ_STATUS_IDX, {5'h0, STATUS_BITS});
    check(irq, 32'h0);
    wr(IRQ_MASK_IDX, 8'h02);
    repeat (2) @(posedge clock);
    check(irq, 32'h1);
    wr(IRQ_STATUS_IDX, 8'h02);
    repeat (2) @(posedge clock);
    check(irq, 32'h0);
    rd(IRQ_STATUS_IDX, 8'h05);
    // a reset in mid-run must clear every register that was loaded
    foreach (IDX[i]) wr(IDX[i], 8'hff);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    check({ack, irq, req, serReq, cfg}, 32'h0);
    foreach (IDX[i]) rd(IDX[i], 8'h00);
    rd(IRQ_STATUS_IDX, 8'h00);
    results();
  end
endmodule : ext_edge_interrupt_control_bench
`default_nettype wire
